// ===== core/omc_pkg.sv
package omc_pkg;

    // Command codes
    localparam logic [7:0] CMD_PAGE      = 8'h00;
    localparam logic [7:0] CMD_OPER      = 8'h01;

    // Page encodings {bit 7, bit 0}
    localparam logic [1:0] PAGE_CH0      = 2'h0;
    localparam logic [1:0] PAGE_CH1      = 2'h1;
    localparam logic [1:0] PAGE_ILLEGAL  = 2'h2;
    localparam logic [1:0] PAGE_BOTH     = 2'h3;
    localparam int         PAGE_HI_BIT   = 7;
    localparam int         PAGE_LO_BIT   = 0;
    localparam logic [1:0] PAGE_RESET    = 2'h0;

    // Output enable and margin register layout
    localparam int         ON_BIT        = 7;
    localparam int         MARGIN_LSB    = 2;
    localparam int         MARGIN_MSB    = 5;
    localparam logic [7:0] OPER_RESET    = 8'h00;

    // Margin codes
    localparam logic [3:0] MARGIN_OFF    = 4'h0;
    localparam logic [3:0] MARGIN_LO_IGN = 4'h5;
    localparam logic [3:0] MARGIN_LO_ACT = 4'h6;
    localparam logic [3:0] MARGIN_HI_IGN = 4'h9;
    localparam logic [3:0] MARGIN_HI_ACT = 4'ha;

    localparam logic [15:0] OFFSET_RESET = 16'h0000;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] wdata;
    } omc_req_type;

    typedef struct packed {
        logic       ack;
        logic       nack;
        logic [7:0] rdata;
    } omc_rsp_type;

    typedef struct packed {
        logic       on;
        logic [3:0] margin;
    } omc_oper_type;

    typedef struct packed {
        logic [1:0]               page;
        omc_oper_type [1:0]       oper;
        omc_rsp_type              rsp;
        logic                     fault;
        logic [1:0]               en;
        logic [1:0]               ignore;
        logic [1:0][15:0]         offset;
        logic [1:0]               pin_s1;
        logic [1:0]               pin_s2;
        logic                     vin_s1;
        logic                     vin_s2;
    } omc_state_type;

endpackage

// ===== core/omc_output_on_margin.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Page 0 selects channel one copy, page 1 selects channel two copy.
// - With page 11 a write updates both channel copies together.
// - Page 11 reads return channel one; page write 10 is ignored.
// - Writes aimed at a slave channel leave its copy unchanged.
// - Slave channel access is NACKed, sets invalid command fault, alerts.
// - On bit enables output only when bus-on-honour is set.
// - Enable also needs input above threshold and pin response satisfied.
// - On bit and margin field reset to zero, margin off.
// - Margin codes: 0000 off, 0101/0110 low, 1001/1010 high; ignore or act.
// - Margin low loads low step offset; margin high loads high step.
// - Bits 6 and 1:0 ignore writes and read as zero.
module omc_output_on_margin (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire omc_pkg::omc_req_type  i_req,
    input  wire logic                  i_clear_fault,
    input  wire logic [1:0]            i_slave,
    input  wire logic [1:0]            i_bus_on_honour,
    input  wire logic [1:0]            i_pin_response,
    input  wire logic [1:0]            i_channel_control_pin,
    input  wire logic                  i_vin_above_threshold,
    input  wire logic [1:0][15:0]      i_margin_low_step,
    input  wire logic [1:0][15:0]      i_margin_high_step,
    output omc_pkg::omc_rsp_type       o_rsp,
    output logic [1:0]                 o_page,
    output logic [1:0]                 o_output_enable,
    output logic [1:0][15:0]           o_ref_offset,
    output logic [1:0]                 o_fault_ignore,
    output logic                       o_invalid_command_fault,
    output logic                       o_smbalert_out,
    output logic                       o_smbalert_oe
);

    omc_pkg::omc_state_type s;
    omc_pkg::omc_state_type next_s;
    logic [1:0]             tgt_w;
    logic [1:0]             tgt_r;
    logic [1:0]             new_page;

    always_comb begin
        unique case (s.page)
            omc_pkg::PAGE_BOTH: tgt_w = 2'h3;
            omc_pkg::PAGE_CH1:  tgt_w = 2'h2;
            default:            tgt_w = 2'h1;
        endcase
        tgt_r = (s.page == omc_pkg::PAGE_CH1) ? 2'h2 : 2'h1;
    end

    assign new_page = {i_req.wdata[omc_pkg::PAGE_HI_BIT],
                       i_req.wdata[omc_pkg::PAGE_LO_BIT]};

    always_comb begin
        next_s = s;
        next_s.pin_s1 = i_channel_control_pin;
        next_s.pin_s2 = s.pin_s1;
        next_s.vin_s1 = i_vin_above_threshold;
        next_s.vin_s2 = s.vin_s1;
        next_s.rsp.ack = 1'b0;
        next_s.rsp.nack = 1'b0;
        if (i_clear_fault) begin
            next_s.fault = 1'b0;
        end
        if (i_req.valid) begin
            unique case (i_req.code)
                omc_pkg::CMD_PAGE: begin
                    next_s.rsp.ack = 1'b1;
                    if (i_req.write) begin
                        if (new_page != omc_pkg::PAGE_ILLEGAL) begin
                            next_s.page = new_page;
                        end
                    end else begin
                        next_s.rsp.rdata = {s.page[1], 6'h00, s.page[0]};
                    end
                end
                omc_pkg::CMD_OPER: begin
                    if (i_req.write) begin
                        for (int c = 0; c < 2; c++) begin
                            // Slave copies keep their contents
                            if (tgt_w[c] && !i_slave[c]) begin
                                next_s.oper[c].on =
                                    i_req.wdata[omc_pkg::ON_BIT];
                                next_s.oper[c].margin =
                                    i_req.wdata[omc_pkg::MARGIN_MSB:
                                                omc_pkg::MARGIN_LSB];
                            end
                        end
                        if ((tgt_w & i_slave) != 2'h0) begin
                            next_s.rsp.nack = 1'b1;
                            next_s.fault = 1'b1;
                        end else begin
                            next_s.rsp.ack = 1'b1;
                        end
                    end else begin
                        if ((tgt_r & i_slave) != 2'h0) begin
                            next_s.rsp.nack = 1'b1;
                            next_s.fault = 1'b1;
                        end else begin
                            next_s.rsp.ack = 1'b1;
                            next_s.rsp.rdata = tgt_r[1] ?
                                {s.oper[1].on, 1'b0,
                                 s.oper[1].margin, 2'h0} :
                                {s.oper[0].on, 1'b0,
                                 s.oper[0].margin, 2'h0};
                        end
                    end
                end
                default: begin
                    next_s.rsp.nack = 1'b1;
                end
            endcase
        end
        for (int c = 0; c < 2; c++) begin
            next_s.en[c] = s.oper[c].on && i_bus_on_honour[c] &&
                           s.vin_s2 &&
                           (!i_pin_response[c] || s.pin_s2[c]);
            unique case (s.oper[c].margin)
                omc_pkg::MARGIN_LO_IGN,
                omc_pkg::MARGIN_LO_ACT: begin
                    next_s.offset[c] = i_margin_low_step[c];
                end
                omc_pkg::MARGIN_HI_IGN,
                omc_pkg::MARGIN_HI_ACT: begin
                    next_s.offset[c] = i_margin_high_step[c];
                end
                default: begin
                    next_s.offset[c] = omc_pkg::OFFSET_RESET;
                end
            endcase
            next_s.ignore[c] =
                (s.oper[c].margin == omc_pkg::MARGIN_LO_IGN) ||
                (s.oper[c].margin == omc_pkg::MARGIN_HI_IGN);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s <= '0;
            s.page <= omc_pkg::PAGE_RESET;
            s.oper[0] <= {omc_pkg::OPER_RESET[omc_pkg::ON_BIT],
                          omc_pkg::OPER_RESET[omc_pkg::MARGIN_MSB:
                                              omc_pkg::MARGIN_LSB]};
            s.oper[1] <= {omc_pkg::OPER_RESET[omc_pkg::ON_BIT],
                          omc_pkg::OPER_RESET[omc_pkg::MARGIN_MSB:
                                              omc_pkg::MARGIN_LSB]};
        end else begin
            s <= next_s;
        end
    end

    assign o_rsp                   = s.rsp;
    assign o_page                  = s.page;
    assign o_output_enable         = s.en;
    assign o_ref_offset            = s.offset;
    assign o_fault_ignore          = s.ignore;
    assign o_invalid_command_fault = s.fault;
    // Open-drain alert: pulled low while a fault is pending
    assign o_smbalert_out          = 1'b0;
    assign o_smbalert_oe           = s.fault;

    sequence q_page_write(logic [1:0] pg);
        i_req.valid && i_req.write && i_req.code == omc_pkg::CMD_PAGE &&
        new_page == pg;
    endsequence

    sequence q_oper_write;
        i_req.valid && i_req.write && i_req.code == omc_pkg::CMD_OPER;
    endsequence

    sequence q_oper_read;
        i_req.valid && !i_req.write && i_req.code == omc_pkg::CMD_OPER;
    endsequence

    property p_page_ch1;
        @(posedge i_clk) disable iff (i_rst)
        q_page_write(omc_pkg::PAGE_CH1) |=>
            o_page == omc_pkg::PAGE_CH1 && o_rsp.ack;
    endproperty
    a_page_ch1: assert property (p_page_ch1)
        else $error("page write to channel two not taken");

    property p_both_write;
        @(posedge i_clk) disable iff (i_rst)
        (q_oper_write and (s.page == omc_pkg::PAGE_BOTH && i_slave == 2'h0))
        |=> s.oper[0] == s.oper[1] &&
            s.oper[0].margin == $past(i_req.wdata[5:2]);
    endproperty
    a_both_write: assert property (p_both_write)
        else $error("page 11 write did not update both copies");

    property p_illegal_page;
        @(posedge i_clk) disable iff (i_rst)
        q_page_write(omc_pkg::PAGE_ILLEGAL) |=> $stable(s.page);
    endproperty
    a_illegal_page: assert property (p_illegal_page)
        else $error("illegal page write changed the page");

    property p_both_read;
        @(posedge i_clk) disable iff (i_rst)
        (q_oper_read and (s.page == omc_pkg::PAGE_BOTH && !i_slave[0]))
        |=> o_rsp.ack && o_rsp.rdata[7] == $past(s.oper[0].on) &&
            o_rsp.rdata[5:2] == $past(s.oper[0].margin);
    endproperty
    a_both_read: assert property (p_both_read)
        else $error("page 11 read did not return channel one");

    property p_slave_keep;
        @(posedge i_clk) disable iff (i_rst)
        (q_oper_write and (i_slave[1] && tgt_w[1])) |=> $stable(s.oper[1]);
    endproperty
    a_slave_keep: assert property (p_slave_keep)
        else $error("slave channel copy changed on write");

    property p_slave_nack;
        @(posedge i_clk) disable iff (i_rst)
        ((q_oper_write and ((tgt_w & i_slave) != 2'h0)) or
         (q_oper_read and ((tgt_r & i_slave) != 2'h0)))
        |=> o_rsp.nack && !o_rsp.ack && o_invalid_command_fault &&
            o_smbalert_oe;
    endproperty
    a_slave_nack: assert property (p_slave_nack)
        else $error("slave access not nacked with fault and alert");

    property p_honour_gate;
        @(posedge i_clk) disable iff (i_rst)
        !i_bus_on_honour[0] |=> !o_output_enable[0];
    endproperty
    a_honour_gate: assert property (p_honour_gate)
        else $error("output enabled without bus-on-honour");

    property p_enable_cond;
        @(posedge i_clk) disable iff (i_rst)
        (s.oper[1].on && i_bus_on_honour[1] && s.vin_s2 &&
         (!i_pin_response[1] || s.pin_s2[1])) |=> o_output_enable[1];
    endproperty
    a_enable_cond: assert property (p_enable_cond)
        else $error("output not enabled when all conditions held");

    property p_vin_gate;
        @(posedge i_clk) disable iff (i_rst)
        !i_vin_above_threshold [*3] |=> !o_output_enable[0];
    endproperty
    a_vin_gate: assert property (p_vin_gate)
        else $error("output enabled under input threshold");

    property p_reset_value;
        @(posedge i_clk)
        $past(i_rst) && !i_rst |->
            s.oper[0] == '0 && s.oper[1] == '0 && !o_output_enable[0];
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("register not zero after reset");

    property p_margin_low;
        @(posedge i_clk) disable iff (i_rst)
        s.oper[0].margin == omc_pkg::MARGIN_LO_IGN |=>
            o_ref_offset[0] == $past(i_margin_low_step[0]) &&
            o_fault_ignore[0];
    endproperty
    a_margin_low: assert property (p_margin_low)
        else $error("margin low ignore-fault offset wrong");

    property p_margin_high;
        @(posedge i_clk) disable iff (i_rst)
        s.oper[0].margin == omc_pkg::MARGIN_HI_ACT |=>
            o_ref_offset[0] == $past(i_margin_high_step[0]) &&
            !o_fault_ignore[0];
    endproperty
    a_margin_high: assert property (p_margin_high)
        else $error("margin high act-on-fault offset wrong");

    property p_margin_off;
        @(posedge i_clk) disable iff (i_rst)
        s.oper[1].margin == omc_pkg::MARGIN_OFF |=> o_ref_offset[1] == '0;
    endproperty
    a_margin_off: assert property (p_margin_off)
        else $error("margin off offset not zero");

    property p_ro_bits;
        @(posedge i_clk) disable iff (i_rst)
        q_oper_read |=> !o_rsp.ack || (o_rsp.rdata[6] == 1'b0 &&
                                       o_rsp.rdata[1:0] == 2'h0);
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("read-only bits not zero on read");

    property p_fault_hold;
        @(posedge i_clk) disable iff (i_rst)
        o_invalid_command_fault && !i_clear_fault |=> o_invalid_command_fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault dropped without clear");

    // Unmapped codes are refused without raising the fault
    property p_unknown_code;
        @(posedge i_clk) disable iff (i_rst)
        (i_req.valid && i_req.code != omc_pkg::CMD_PAGE &&
         i_req.code != omc_pkg::CMD_OPER && !o_invalid_command_fault)
        |=> o_rsp.nack && !o_rsp.ack && !o_invalid_command_fault;
    endproperty
    a_unknown_code: assert property (p_unknown_code)
        else $error("unknown command not nacked cleanly");

endmodule

`default_nettype wire

// ===== tb/omc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module omc_host_model (
    input  wire logic                 i_clk,
    input  wire omc_pkg::omc_rsp_type i_rsp,
    output var omc_pkg::omc_req_type  o_req
);
    initial o_req = '0;

    // One-cycle strobe; fields scrambled once released
    task automatic access(input logic wr, input logic [7:0] code,
                          input logic [7:0] wdata, output logic ack,
                          output logic nack, output logic [7:0] rdata);
        @(negedge i_clk);
        o_req = '{valid: 1'b1, write: wr, code: code, wdata: wdata};
        @(negedge i_clk);
        ack   = i_rsp.ack;
        nack  = i_rsp.nack;
        rdata = i_rsp.rdata;
        o_req = '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~wdata};
    endtask
endmodule

`default_nettype wire

// ===== tb/omc_output_on_margin_test.sv
`timescale 1ns/1ns
`default_nettype none

module omc_output_on_margin_test;
    localparam logic [7:0] PG = omc_pkg::CMD_PAGE;
    localparam logic [7:0] OP = omc_pkg::CMD_OPER;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 clr = 1'b0;
    logic                 vin = 1'b0;
    logic [1:0]           slave = 2'h0;
    logic [1:0]           hon = 2'h0;
    logic [1:0]           resp = 2'h0;
    logic [1:0]           pin = 2'h0;
    logic [1:0][15:0]     lo = {16'h2222, 16'h1111};
    logic [1:0][15:0]     hi = {16'h4444, 16'h3333};
    omc_pkg::omc_req_type req;
    omc_pkg::omc_rsp_type rsp;
    logic [1:0]           page;
    logic [1:0]           en;
    logic [1:0]           ign;
    logic [1:0][15:0]     offs;
    logic                 fault;
    logic                 al_out;
    logic                 al_oe;
    int                   n_errors = 0;
    int                   samples_checked = 0;

    always #5 clk = ~clk;

    omc_host_model omc_host_model_i (.i_clk(clk), .i_rsp(rsp), .o_req(req));

    omc_output_on_margin omc_output_on_margin_i (
        .i_clk(clk), .i_rst(rst), .i_req(req), .i_clear_fault(clr),
        .i_slave(slave), .i_bus_on_honour(hon), .i_pin_response(resp),
        .i_channel_control_pin(pin), .i_vin_above_threshold(vin),
        .i_margin_low_step(lo), .i_margin_high_step(hi), .o_rsp(rsp),
        .o_page(page), .o_output_enable(en), .o_ref_offset(offs),
        .o_fault_ignore(ign), .o_invalid_command_fault(fault),
        .o_smbalert_out(al_out), .o_smbalert_oe(al_oe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus access with its answer judged
    task automatic op(input logic wr, input logic [7:0] code,
                      input logic [7:0] d, input logic ok,
                      input logic [7:0] exp);
        logic a;
        logic n;
        logic [7:0] rd;
        omc_host_model_i.access(wr, code, d, a, n, rd);
        check({a, n}, {ok, ~ok});
        if (!wr && ok) check(rd, exp);
    endtask

    task automatic clear_fault;
        @(negedge clk) clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        @(negedge clk);
        check({fault, al_oe}, 2'h0);
    endtask

    task automatic t_reset;
        check({page, en, ign, fault, al_oe, al_out}, 16'h0);
        check(offs[0] | offs[1], 16'h0);
        op(0, OP, 8'h00, 1, 8'h00);
        op(1, PG, 8'h01, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h00);
        op(0, PG, 8'h00, 1, 8'h01);
        op(1, 8'h02, 8'h00, 0, 8'h00);
        check(fault, 1'b0);
        $display("reset test done");
    endtask

    task automatic t_page;
        op(1, OP, 8'hff, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'hbc);
        op(1, PG, 8'h00, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h00);
        op(1, PG, 8'h80, 1, 8'h00);
        check(page, 2'h0);
        op(1, PG, 8'h81, 1, 8'h00);
        op(1, OP, 8'h28, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h28);
        op(1, PG, 8'h01, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h28);
        op(1, OP, 8'h24, 1, 8'h00);
        op(1, PG, 8'h81, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h28);
        op(0, PG, 8'h00, 1, 8'h81);
        $display("page test done");
    endtask

    task automatic t_margin;
        logic [3:0] codes [5] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'ha};
        logic [15:0] offx [5] = '{16'h0, 16'h1111, 16'h1111,
                                  16'h3333, 16'h3333};
        logic ignx [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        op(1, PG, 8'h00, 1, 8'h00);
        for (int i = 0; i < 5; i++) begin
            op(1, OP, {2'b00, codes[i], 2'b00}, 1, 8'h00);
            @(negedge clk);
            check(offs[0], offx[i]);
            check(ign[0], ignx[i]);
        end
        $display("margin test done");
    endtask

    task automatic t_enable;
        // Honour clear in the first step: the on bit must have no effect
        logic [4:0] cs [6] = '{5'b01010, 5'b11001, 5'b11100, 5'b11111,
                               5'b10010, 5'b11110};
        op(1, OP, 8'h80, 1, 8'h00);
        for (int i = 0; i < 6; i++) begin
            if (i == 5) op(1, OP, 8'h00, 1, 8'h00);
            @(negedge clk);
            hon  = {2{cs[i][4]}};
            vin  = cs[i][3];
            resp = {2{cs[i][2]}};
            pin  = {2{cs[i][1]}};
            repeat (4) @(negedge clk);
            check(en, {1'b0, cs[i][0]});
        end
        $display("enable test done");
    endtask

    task automatic t_slave;
        slave = 2'h2;
        op(1, PG, 8'h01, 1, 8'h00);
        op(1, OP, 8'h80, 0, 8'h00);
        @(negedge clk);
        check({fault, al_oe, al_out}, 3'h6);
        op(0, OP, 8'h00, 0, 8'h00);
        clear_fault();
        op(1, PG, 8'h81, 1, 8'h00);
        op(1, OP, 8'h14, 0, 8'h00);
        slave = 2'h0;
        op(0, OP, 8'h00, 1, 8'h14);
        op(1, PG, 8'h01, 1, 8'h00);
        op(0, OP, 8'h00, 1, 8'h24);
        clear_fault();
        $display("slave test done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        t_reset();
        t_page();
        t_margin();
        t_enable();
        t_slave();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule

`default_nettype wire
